/* File: hw/pwt_defs.vh */
// Constants for the wiper potentiometer serial target
`ifndef PWT_DEFS_VH
`define PWT_DEFS_VH
`define PWT_ADDR_WIPER      8'h00
`define PWT_ADDR_RESERVED   8'h01
`define PWT_ADDR_ACCESS     8'h02
`define PWT_ACCESS_NV       8'h00
`define PWT_ACCESS_VOL      8'h80
`define PWT_ACCESS_RESET    8'h00
`define PWT_WIPER_RESET     8'h80
`define PWT_NV_RESET        8'h80
`define PWT_DIR_BIT         0
// Counts in core clock cycles at 125 MHz, sized to their parameters
`define PWT_NV_WRITE_CYC    24'h16E360 // 12 ms store
`define PWT_POWERUP_CYC     16'h007D   // 1 us recall
`endif

/* File: hw/pwt_target.v */
// Serial two-wire target for a single digitally controlled potentiometer
`timescale 1ns/1ps
`default_nettype none
`include "pwt_defs.vh"

module pwt_target
#(
    parameter [6:0]  DEV_SELECT  = 7'h2A, // Arbitrary select value
    parameter [23:0] NV_CYCLES   = `PWT_NV_WRITE_CYC,
    parameter [15:0] PWRUP_CYCLES = `PWT_POWERUP_CYC
)
(
    input  wire       core_clk,
    input  wire       resetn,
    input  wire       clk_en,
    input  wire       scl_in,
    input  wire       sda_in,
    output reg        sda_out,
    output reg        sda_oe_n,
    input  wire       write_protect_n,
    output reg  [7:0] wiper_position,
    output reg  [7:0] access_select,
    output reg  [7:0] power_on_wiper_value,
    output reg        nv_busy
);

localparam [2:0] ST_IDLE = 3'h0;
localparam [2:0] ST_ID   = 3'h1;
localparam [2:0] ST_ADDR = 3'h2;
localparam [2:0] ST_DATA = 3'h3;
localparam [2:0] ST_READ = 3'h4;
localparam [2:0] ST_NV   = 3'h5;
localparam [2:0] ST_PWR  = 3'h6;

// Three-stage sync; only stages two and three are compared
reg  [2:0]  scl_sync;
reg  [2:0]  sda_sync;
reg  [2:0]  wp_sync;
reg         scl_q;
reg         sda_q;
reg         wp_q;
reg  [2:0]  state;
reg  [3:0]  bit_cnt;
reg  [7:0]  shift;
reg  [7:0]  addr;
reg         rd_dir;
reg         ack_phase;
reg         nv_pending;
reg  [23:0] timer;
wire        scl_rise;
wire        scl_fall;
wire        start_det;
wire        stop_det;
wire [7:0]  read_val;

assign scl_rise  = scl_q == 1'b0 && scl_sync[2] == 1'b1
                   && scl_sync[1] == 1'b1;
assign scl_fall  = scl_q == 1'b1 && scl_sync[2] == 1'b0
                   && scl_sync[1] == 1'b0;
assign start_det = scl_q && sda_q && sda_sync[2] == 1'b0
                   && sda_sync[1] == 1'b0;
assign stop_det  = scl_q && !sda_q && sda_sync[2] == 1'b1
                   && sda_sync[1] == 1'b1;
assign read_val  = (addr == `PWT_ADDR_ACCESS) ? access_select :
                   (addr != `PWT_ADDR_WIPER) ? 8'h00 :
                   (access_select == `PWT_ACCESS_NV) ?
                   power_on_wiper_value : wiper_position;

always @(posedge core_clk)
begin
    if (!resetn)
    begin
        scl_sync <= 3'h7;
        sda_sync <= 3'h7;
        wp_sync  <= 3'h7;
        scl_q    <= 1'b1;
        sda_q    <= 1'b1;
        wp_q     <= 1'b1;
    end
    else if (clk_en)
    begin
        scl_sync <= {scl_sync[1:0], scl_in};
        sda_sync <= {sda_sync[1:0], sda_in};
        wp_sync  <= {wp_sync[1:0], write_protect_n};
        if (scl_sync[2] == scl_sync[1])
            scl_q <= scl_sync[2];
        if (sda_sync[2] == sda_sync[1])
            sda_q <= sda_sync[2];
        if (wp_sync[2] == wp_sync[1])
            wp_q <= wp_sync[2];
    end
end

always @(posedge core_clk)
begin
    if (!resetn)
    begin
        state      <= ST_PWR;
        sda_out    <= 1'b0;
        sda_oe_n   <= 1'b1;
        bit_cnt    <= 4'h0;
        shift      <= 8'h00;
        addr       <= 8'h00;
        rd_dir     <= 1'b0;
        ack_phase  <= 1'b0;
        nv_pending <= 1'b0;
        timer      <= 24'h000000;
        nv_busy    <= 1'b1;
        wiper_position       <= `PWT_WIPER_RESET;
        access_select        <= `PWT_ACCESS_RESET;
        power_on_wiper_value <= `PWT_NV_RESET;
    end
    else if (clk_en)
    begin
        case (state)
        ST_PWR:
        begin
            sda_oe_n <= 1'b1;
            if (timer == {8'h00, PWRUP_CYCLES})
            begin
                timer          <= 24'h000000;
                wiper_position <= power_on_wiper_value;
                nv_busy        <= 1'b0;
                state          <= ST_IDLE;
            end
            else
                timer <= timer + 24'h000001;
        end
        ST_NV:
        begin
            sda_oe_n <= 1'b1;
            if (timer == NV_CYCLES)
            begin
                timer   <= 24'h000000;
                nv_busy <= 1'b0;
                state   <= ST_IDLE;
            end
            else
                timer <= timer + 24'h000001;
        end
        default:
        begin
            if (stop_det)
            begin
                sda_oe_n <= 1'b1;
                if (nv_pending)
                begin
                    // Stored copy changes only once the stop arrives
                    power_on_wiper_value <= wiper_position;
                    nv_pending <= 1'b0;
                    nv_busy    <= 1'b1;
                    timer      <= 24'h000000;
                    state      <= ST_NV;
                end
                else
                    state <= ST_IDLE;
            end
            else if (start_det)
            begin
                sda_oe_n   <= 1'b1;
                bit_cnt    <= 4'h0;
                ack_phase  <= 1'b0;
                nv_pending <= 1'b0;
                state      <= ST_ID;
            end
            else if (state != ST_IDLE && scl_rise && !ack_phase)
            begin
                // msb first shift
                // Outgoing read data shifts on falls, so rises only count
                if (state != ST_READ)
                    shift <= {shift[6:0], sda_q};
                bit_cnt <= bit_cnt + 4'h1;
            end
            // Ack release still due after a byte that ended in idle
            else if ((state != ST_IDLE || ack_phase) && scl_fall)
            begin
                if (ack_phase)
                begin
                    ack_phase <= 1'b0;
                    bit_cnt   <= 4'h0;
                    sda_oe_n  <= 1'b1;
                    // data byte follows the read id
                    if (state == ST_READ)
                    begin
                        // Open drain: a one is sent by releasing the line
                        sda_out  <= read_val[7];
                        sda_oe_n <= read_val[7];
                        shift    <= {read_val[6:0], 1'b0};
                    end
                end
                else if (state == ST_READ)
                begin
                    if (bit_cnt == 4'h8)
                    begin
                        sda_oe_n <= 1'b1;
                        state    <= ST_IDLE;
                    end
                    else
                    begin
                        sda_out  <= shift[7];
                        sda_oe_n <= shift[7];
                        shift    <= {shift[6:0], 1'b0};
                    end
                end
                else if (bit_cnt == 4'h8)
                begin
                    ack_phase <= 1'b1;
                    case (state)
                    ST_ID:
                    begin
                        if (shift[7:1] == DEV_SELECT)
                        begin
                            sda_out  <= 1'b0;
                            sda_oe_n <= 1'b0;
                            rd_dir   <= shift[`PWT_DIR_BIT];
                            state    <= shift[`PWT_DIR_BIT] ?
                                        ST_READ : ST_ADDR;
                        end
                        else
                            state <= ST_IDLE;
                    end
                    ST_ADDR:
                    begin
                        sda_out  <= 1'b0;
                        sda_oe_n <= 1'b0;
                        addr     <= shift;
                        state    <= ST_DATA;
                    end
                    default:
                    begin
                        if (!wp_q)
                            state <= ST_IDLE;
                        else
                        begin
                            sda_out  <= 1'b0;
                            sda_oe_n <= 1'b0;
                            if (addr == `PWT_ADDR_ACCESS)
                                access_select <= shift;
                            else if (addr == `PWT_ADDR_WIPER)
                            begin
                                wiper_position <= shift;
                                if (access_select == `PWT_ACCESS_NV)
                                begin
                                    // Store waits for the closing stop
                                    nv_pending <= 1'b1;
                                end
                            end
                            state <= ST_IDLE;
                        end
                    end
                    endcase
                end
            end
        end
        endcase
    end
end

endmodule // pwt_target
`default_nettype wire

/* File: test/pwt_checker.sv */
// Port checker for the potentiometer serial target
`timescale 1ns/1ps
`default_nettype none
module pwt_checker
#(
    parameter [23:0] NV_CYCLES    = 24'h32,
    parameter [15:0] PWRUP_CYCLES = 16'h8
)
(
    input wire logic       core_clk,
    input wire logic       resetn,
    input wire logic       clk_en,
    input wire logic       scl_in,
    input wire logic       sda_in,
    input wire logic       sda_out,
    input wire logic       sda_oe_n,
    input wire logic       write_protect_n,
    input wire logic [7:0] wiper_position,
    input wire logic [7:0] access_select,
    input wire logic [7:0] power_on_wiper_value,
    input wire logic       nv_busy
);
    logic [23:0] cnt;
    logic [3:0]  wp_cnt;
    logic        pwr;
    // Power-up and store share nv_busy, so pwr tells them apart
    always @(posedge core_clk)
    begin
        if (!resetn)
        begin
            cnt    <= 24'h0;
            wp_cnt <= 4'h0;
            pwr    <= 1'b1;
        end
        else if (clk_en)
        begin
            cnt    <= nv_busy ? cnt + 24'h1 : 24'h0;
            wp_cnt <= write_protect_n ? 4'h0 : wp_cnt + {3'h0, ~&wp_cnt};
            pwr    <= pwr & nv_busy;
        end
    end
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!resetn);
    reset_state_a: assert property (disable iff (1'b0)
        !resetn && clk_en |=> sda_oe_n && nv_busy && access_select == 8'h00)
        else $error("bad reset state");
    drive_low_a: assert property (!sda_oe_n |-> !sda_out)
        else $error("drive value not low");
    scl_low_a: assert property ($changed(sda_oe_n) |-> !scl_in)
        else $error("data moved with clock high");
    busy_quiet_a: assert property (nv_busy |-> sda_oe_n)
        else $error("drive while busy");
    busy_hold_a: assert property (nv_busy |=>
        $stable(power_on_wiper_value) && $stable(access_select))
        else $error("register moved while busy");
    store_len_a: assert property ($fell(nv_busy) && !pwr |->
        cnt >= NV_CYCLES && cnt <= NV_CYCLES + 24'h2)
        else $error("store length wrong");
    pwrup_len_a: assert property ($fell(nv_busy) && pwr |->
        cnt >= {8'h00, PWRUP_CYCLES} && cnt <= {8'h00, PWRUP_CYCLES} + 24'h3)
        else $error("power-up length wrong");
    wp_hold_a: assert property (wp_cnt == 4'hF && !pwr |=>
        $stable(wiper_position) && $stable(access_select))
        else $error("write under protect");
    ack_span_a: assert property ($fell(sda_oe_n) |-> !sda_oe_n [*8])
        else $error("drive too short");
    cover property ($fell(sda_oe_n));
    cover property ($rose(nv_busy) && !pwr);
    cover property (wp_cnt == 4'hF && $fell(scl_in));
endmodule // pwt_checker
bind pwt_target pwt_checker #(
    .NV_CYCLES   (NV_CYCLES),
    .PWRUP_CYCLES(PWRUP_CYCLES)
) chk (
    .core_clk(core_clk), .resetn(resetn), .clk_en(clk_en),
    .scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out),
    .sda_oe_n(sda_oe_n), .write_protect_n(write_protect_n),
    .wiper_position(wiper_position), .access_select(access_select),
    .power_on_wiper_value(power_on_wiper_value), .nv_busy(nv_busy)
);
`default_nettype wire

/* File: test/pwt_master.sv */
// Behavioural two-wire bus master
`timescale 1ns/1ps
`default_nettype none
module pwt_master
(
    input  wire logic core_clk,
    input  wire logic sda,
    output var  logic scl,
    output var  logic sda_m
);
    initial
    begin
        scl   = 1'b1;
        sda_m = 1'b1;
    end
    task automatic half;
        repeat (10) @(negedge core_clk);
    endtask
    // data moves only after the clock has settled low
    task automatic bitx(input logic b, output logic r);
        repeat (2) @(negedge core_clk);
        sda_m = b;
        half;
        scl = 1'b1;
        half;
        r = sda;
        scl = 1'b0;
    endtask
    task automatic start;
        repeat (2) @(negedge core_clk);
        sda_m = 1'b1;
        half;
        scl = 1'b1;
        half;
        sda_m = 1'b0;
        half;
        scl = 1'b0;
    endtask
    task automatic stop;
        repeat (2) @(negedge core_clk);
        sda_m = 1'b0;
        half;
        scl = 1'b1;
        half;
        sda_m = 1'b1;
        half;
    endtask
    // MSB first, line released on the ninth pulse
    task automatic wbyte(input logic [7:0] v, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--)
            bitx(v[i], r);
        bitx(1'b1, r);
        ack = ~r;
    endtask
    task automatic rbyte(output logic [7:0] v, input logic ack);
        logic r;
        for (int i = 7; i >= 0; i--)
        begin
            bitx(1'b1, r);
            v[i] = r;
        end
        bitx(~ack, r);
    endtask
endmodule // pwt_master
`default_nettype wire

/* File: test/pot_wiper_i2c_target_tb_top.sv */
// Self-checking bench for the potentiometer serial target
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin tests_run++; if ((a) !== (e)) begin n_errors++; \
    $display("unexpected at %0t: got %h want %h", $time, a, e); end end
module pot_wiper_i2c_target_tb_top;
    localparam [7:0] IDW = {7'h2A, 1'b0};
    localparam [7:0] IDR = {7'h2A, 1'b1};
    logic       core_clk, resetn, wp_n, sda_out, sda_oe_n, nv_busy;
    logic       scl, sda_m;
    logic [7:0] wiper, acc, pov, d;
    logic [2:0] k;
    int         n_errors, tests_run, cyc;
    // Open drain with pull-up: released means high
    wire logic  sda = sda_m & (sda_oe_n | sda_out);
    pwt_target #(.DEV_SELECT(7'h2A), .NV_CYCLES(24'h32), .PWRUP_CYCLES(16'h8))
    uut (.core_clk(core_clk), .resetn(resetn), .clk_en(1'b1),
        .scl_in(scl), .sda_in(sda), .sda_out(sda_out), .sda_oe_n(sda_oe_n),
        .write_protect_n(wp_n), .wiper_position(wiper), .access_select(acc),
        .power_on_wiper_value(pov), .nv_busy(nv_busy));
    pwt_master m (.core_clk(core_clk), .sda(sda), .scl(scl), .sda_m(sda_m));
    task automatic close_out;
        $display("tests_run %0d n_errors %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    task automatic wr(input logic [7:0] id, a, v);
        m.start;
        m.wbyte(id, k[2]);
        m.wbyte(a, k[1]);
        m.wbyte(v, k[0]);
        m.stop;
    endtask
    task automatic rd(input logic [7:0] a);
        m.start;
        m.wbyte(IDW, k[2]);
        m.wbyte(a, k[1]);
        m.start;
        m.wbyte(IDR, k[0]);
        m.rbyte(d, 1'b1);
        m.stop;
    endtask
    task automatic settle;
        for (int i = 0; i < 200 && nv_busy !== 1'b0; i++)
            @(negedge core_clk);
    endtask
    initial
    begin
        core_clk = 1'b0;
        forever #4 core_clk = ~core_clk;
    end
    always @(posedge core_clk)
    begin
        cyc++;
        if (cyc == 40000)
        begin
            n_errors++;
            close_out;
        end
    end
    initial
    begin
        resetn = 1'b0;
        wp_n = 1'b1;
        repeat (3) @(negedge core_clk);
        resetn = 1'b1;
        `CHK(sda_oe_n, 1'b1)
        `CHK(nv_busy, 1'b1)
        settle;
        `CHK({wiper, acc}, 16'h8000)
        $display("reset test done");
        wr(IDW, 8'h00, 8'h55);
        `CHK(k, 3'b111)
        `CHK(nv_busy, 1'b1)
        `CHK({wiper, pov}, 16'h5555)
        wr(IDW, 8'h00, 8'h11);
        `CHK(k, 3'b000)
        `CHK(wiper, 8'h55)
        settle;
        rd(8'h00);
        `CHK({k, d}, 11'h755)
        $display("stored write test done");
        wr(IDW, 8'h02, 8'h80);
        `CHK(acc, 8'h80)
        wr(IDW, 8'h00, 8'h3C);
        `CHK(nv_busy, 1'b0)
        `CHK({wiper, pov}, 16'h3C55)
        rd(8'h00);
        `CHK(d, 8'h3C)
        rd(8'h02);
        `CHK(d, 8'h80)
        $display("volatile test done");
        wr({7'h2B, 1'b0}, 8'h00, 8'hAA);
        `CHK(k, 3'b000)
        wr(IDW, 8'h01, 8'hAA);
        `CHK(k, 3'b111)
        `CHK({wiper, acc, pov}, 24'h3C8055)
        $display("refusal test done");
        wp_n = 1'b0;
        wr(IDW, 8'h00, 8'h99);
        `CHK(k, 3'b110)
        `CHK(wiper, 8'h3C)
        wp_n = 1'b1;
        $display("protect test done");
        close_out;
    end
endmodule // pot_wiper_i2c_target_tb_top
`default_nettype wire
